// ### verilog/mpf_pkg.sv
// Shared constants, types and header helpers of the MAC frame framer
package mpf_pkg;

  // Frame layout, in bytes
  localparam int HDR_BYTES = 3;
  localparam int PKT_HDR_BYTES = 7;
  localparam int CRC_BYTES = 4;
  localparam int SNA_BYTES = 6;
  localparam int SNA_W = 8 * SNA_BYTES;
  localparam logic [1:0] HDR_IDX_LAST = 2'h2;
  localparam logic [1:0] CRC_IDX_LAST = 2'h3;
  localparam logic [3:0] FRAME_MIN_M1 =
    4'(HDR_BYTES + PKT_HDR_BYTES + CRC_BYTES - 1);
  localparam logic [3:0] FIDX_MAX = 4'hF;

  // Header field values and positions
  localparam logic [1:0] ALIGN_VAL = 2'h0;
  localparam logic [1:0] HT_GENERIC = 2'h0;
  localparam logic [3:0] RSV_HI_VAL = 4'h0;
  localparam logic RSV_LO_VAL = 1'h0;
  localparam int B0_ALIGN_MSB = 7;
  localparam int B0_ALIGN_LSB = 6;
  localparam int B0_HT_MSB = 5;
  localparam int B0_HT_LSB = 4;
  localparam int B0_RSV_MSB = 3;
  localparam int B1_RSV_BIT = 7;
  localparam int B1_DL_BIT = 6;
  localparam int B1_LVL_MSB = 5;

  // Header check: g(x) = x^8 + x^2 + x + 1, register cleared at start
  localparam logic [7:0] HCS_POLY = 8'h07;
  localparam logic [7:0] HCS_INIT = 8'h00;

  // APB register map of the PHY-side end
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] REG_TXD = 12'h000;
  localparam logic [APB_AW-1:0] REG_RXD = 12'h004;
  localparam logic [APB_AW-1:0] REG_STAT = 12'h008;
  localparam logic [APB_AW-1:0] REG_MASK = 12'h00C;
  localparam int TXD_LAST_BIT = 8;
  localparam int RXD_LAST_BIT = 8;
  localparam int RXD_FULL_BIT = 9;

  // Status and mask bit positions
  localparam int ST_W = 6;
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_FRAME_END = 1;
  localparam int ST_HDR_BAD = 2;
  localparam int ST_SHORT = 3;
  localparam int ST_TX_TAKEN = 4;
  localparam int ST_TX_OVR = 5;

  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY, TX_CRC} mpf_tx_st_t;
  typedef enum logic [1:0] {RX_HDR, RX_PAY, RX_DROP} mpf_rx_st_t;
  typedef enum logic [2:0] {
    SEL_TXD, SEL_RXD, SEL_STAT, SEL_MASK, SEL_NONE
  } mpf_sel_t;

  function automatic logic [7:0] mpf_byte0(input logic [1:0] ht);
    return {ALIGN_VAL, ht, RSV_HI_VAL};
  endfunction

  function automatic logic [7:0] mpf_byte1(input logic dl,
                                           input logic [5:0] lvl);
    return {RSV_LO_VAL, dl, lvl};
  endfunction

  // Alignment, type and reserved bits as a generic frame demands
  function automatic logic mpf_hdr_clean(input logic [7:0] b0,
                                         input logic [7:0] b1);
    return b0[B0_ALIGN_MSB:B0_ALIGN_LSB] == ALIGN_VAL &&
           b0[B0_HT_MSB:B0_HT_LSB] == HT_GENERIC &&
           b0[B0_RSV_MSB:0] == RSV_HI_VAL &&
           b1[B1_RSV_BIT] == RSV_LO_VAL;
  endfunction

  function automatic logic [7:0] mpf_hcs_step(input logic [7:0] crc,
                                              input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'h0} ^ HCS_POLY;
      end else begin
        c = {c[6:0], 1'h0};
      end
    end
    return c;
  endfunction

  // Address first, top byte first, then the two leading header bytes
  function automatic logic [7:0] mpf_hcs(input logic [SNA_W-1:0] subnetwork_address,
                                         input logic [7:0] b0,
                                         input logic [7:0] b1);
    logic [7:0] c;
    c = HCS_INIT;
    for (int i = SNA_BYTES - 1; i >= 0; i--) begin
      c = mpf_hcs_step(c, subnetwork_address[i*8 +: 8]);
    end
    c = mpf_hcs_step(c, b0);
    c = mpf_hcs_step(c, b1);
    return c;
  endfunction

endpackage

// ### verilog/mpf_link_if.sv
// Byte stream link between the framer and the PHY-side end
interface mpf_link_if;
  // Framer to PHY side
  logic [7:0] dp_data;
  logic dp_valid;
  logic dp_last;
  logic dp_ready;
  // PHY side to framer
  logic [7:0] pd_data;
  logic pd_valid;
  logic pd_last;
  logic pd_ready;

  modport dev (
    output dp_data, dp_valid, dp_last,
    input dp_ready,
    input pd_data, pd_valid, pd_last,
    output pd_ready
  );

  modport phy (
    input dp_data, dp_valid, dp_last,
    output dp_ready,
    output pd_data, pd_valid, pd_last,
    input pd_ready
  );
endinterface

// ### verilog/mpf_framer.sv
// MAC frame framer: builds and checks the generic frame header
// Summary of operation
// - Reserved bits of built frames are zero
// - Header, one or more packets, then CRC32
// - Three header bytes, MSB first, check last
// - Two alignment bits always zero
// - Header type zero marks generic frame
// - Four plus one reserved header bits zero
// - Direction flag one downlink, zero uplink
// - Six-bit level encodes hierarchy hop
// - Level is transmitter's uplink, receiver's downlink
// - Check byte over address and two bytes
// - Check is remainder by x8+x2+x+1
// - Check input fed MSB first, address first
// - Receiver recomputes check with own address
// - Extension flagged by reserved bit, appended; none is built, and a received frame with a reserved bit set raises rx_hdr_err
// - Each packet opens with seven-byte header
module mpf_framer (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Own subnetwork address
  input wire logic [mpf_pkg::SNA_W-1:0] subnetwork_address,
  // Transmit request
  input wire logic tx_start,
  input wire logic tx_downlink,
  input wire logic [5:0] tx_level,
  input wire logic [31:0] tx_crc32,
  output logic tx_idle,
  output logic tx_done,
  // Transmit packet bytes
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // Received frame
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  output logic rx_hdr_ok,
  output logic rx_hdr_err,
  output logic rx_downlink,
  output logic [5:0] rx_level,
  // Link to the PHY side
  mpf_link_if.dev lnk
);
  import mpf_pkg::*;

  typedef struct packed {
    mpf_tx_st_t tx_st;
    logic [1:0] tx_idx;
    logic [7:0] hdr0;
    logic [7:0] hdr1;
    logic [7:0] hdr2;
    logic [31:0] crc32;
    logic [7:0] dp_data;
    logic dp_valid;
    logic dp_last;
    logic tx_idle;
    logic tx_ready;
    logic tx_done;
    mpf_rx_st_t rx_st;
    logic [1:0] rx_idx;
    logic [7:0] rb0;
    logic [7:0] rb1;
    logic pd_ready;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_last;
    logic rx_hdr_ok;
    logic rx_hdr_err;
    logic rx_downlink;
    logic [5:0] rx_level;
  } mpf_dev_state_t;

  mpf_dev_state_t s;
  mpf_dev_state_t next_s;

  always_comb begin
    logic [7:0] b0;
    logic [7:0] b1;
    logic slot_free;
    logic hdr_good;
    b0 = 8'h00;
    b1 = 8'h00;
    slot_free = 1'h0;
    hdr_good = 1'h0;
    next_s = s;
    next_s.tx_done = 1'h0;
    next_s.rx_valid = 1'h0;
    next_s.rx_last = 1'h0;
    next_s.rx_hdr_ok = 1'h0;
    next_s.rx_hdr_err = 1'h0;
    // Receive side never stalls the link once out of reset
    next_s.pd_ready = 1'h1;

    // Output byte slot empties when the PHY side takes it
    if (s.dp_valid && lnk.dp_ready) begin
      next_s.dp_valid = 1'h0;
    end
    slot_free = !next_s.dp_valid;

    case (s.tx_st)
      TX_IDLE: begin
        if (tx_start) begin
          b0 = mpf_byte0(HT_GENERIC);
          b1 = mpf_byte1(tx_downlink, tx_level);
          next_s.hdr0 = b0;
          next_s.hdr1 = b1;
          next_s.hdr2 = mpf_hcs(subnetwork_address, b0, b1);
          next_s.crc32 = tx_crc32;
          next_s.tx_idx = 2'h0;
          next_s.tx_st = TX_HDR;
          next_s.tx_idle = 1'h0;
        end
      end
      TX_HDR: begin
        if (slot_free) begin
          if (s.tx_idx == 2'h0) begin
            next_s.dp_data = s.hdr0;
          end else if (s.tx_idx == 2'h1) begin
            next_s.dp_data = s.hdr1;
          end else begin
            next_s.dp_data = s.hdr2;
          end
          next_s.dp_valid = 1'h1;
          next_s.dp_last = 1'h0;
          if (s.tx_idx == HDR_IDX_LAST) begin
            next_s.tx_st = TX_PAY;
          end else begin
            next_s.tx_idx = s.tx_idx + 2'h1;
          end
        end
      end
      TX_PAY: begin
        // Ready is registered, so a byte moves every other cycle at best
        if (tx_valid && s.tx_ready) begin
          next_s.dp_data = tx_data;
          next_s.dp_valid = 1'h1;
          next_s.dp_last = 1'h0;
          next_s.tx_ready = 1'h0;
          if (tx_last) begin
            next_s.tx_st = TX_CRC;
            next_s.tx_idx = 2'h0;
          end
        end else if (slot_free) begin
          next_s.tx_ready = 1'h1;
        end
      end
      TX_CRC: begin
        if (slot_free) begin
          next_s.dp_data = s.crc32[31:24];
          next_s.crc32 = {s.crc32[23:0], 8'h00};
          next_s.dp_valid = 1'h1;
          next_s.dp_last = s.tx_idx == CRC_IDX_LAST;
          if (s.tx_idx == CRC_IDX_LAST) begin
            next_s.tx_st = TX_IDLE;
            next_s.tx_idle = 1'h1;
            next_s.tx_done = 1'h1;
          end else begin
            next_s.tx_idx = s.tx_idx + 2'h1;
          end
        end
      end
      default: begin
        next_s.tx_st = TX_IDLE;
        next_s.tx_idle = 1'h1;
      end
    endcase

    if (lnk.pd_valid && s.pd_ready) begin
      case (s.rx_st)
        RX_HDR: begin
          if (s.rx_idx == 2'h0) begin
            next_s.rb0 = lnk.pd_data;
          end else if (s.rx_idx == 2'h1) begin
            next_s.rb1 = lnk.pd_data;
          end
          if (s.rx_idx == HDR_IDX_LAST) begin
            hdr_good = lnk.pd_data == mpf_hcs(subnetwork_address, s.rb0, s.rb1) &&
                       mpf_hdr_clean(s.rb0, s.rb1) && !lnk.pd_last;
            next_s.rx_idx = 2'h0;
            if (hdr_good) begin
              next_s.rx_hdr_ok = 1'h1;
              next_s.rx_downlink = s.rb1[B1_DL_BIT];
              next_s.rx_level = s.rb1[B1_LVL_MSB:0];
              next_s.rx_st = RX_PAY;
            end else begin
              next_s.rx_hdr_err = 1'h1;
              // A frame that ends on its check byte leaves nothing to skip
              if (lnk.pd_last) begin
                next_s.rx_st = RX_HDR;
              end else begin
                next_s.rx_st = RX_DROP;
              end
            end
          end else if (lnk.pd_last) begin
            next_s.rx_hdr_err = 1'h1;
            next_s.rx_idx = 2'h0;
          end else begin
            next_s.rx_idx = s.rx_idx + 2'h1;
          end
        end
        RX_PAY: begin
          next_s.rx_data = lnk.pd_data;
          next_s.rx_valid = 1'h1;
          next_s.rx_last = lnk.pd_last;
          if (lnk.pd_last) begin
            next_s.rx_st = RX_HDR;
          end
        end
        RX_DROP: begin
          if (lnk.pd_last) begin
            next_s.rx_st = RX_HDR;
          end
        end
        default: begin
          next_s.rx_st = RX_HDR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.tx_idle <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.dp_data = s.dp_data;
  assign lnk.dp_valid = s.dp_valid;
  assign lnk.dp_last = s.dp_last;
  assign lnk.pd_ready = s.pd_ready;
  assign tx_idle = s.tx_idle;
  assign tx_done = s.tx_done;
  assign tx_ready = s.tx_ready;
  assign rx_data = s.rx_data;
  assign rx_valid = s.rx_valid;
  assign rx_last = s.rx_last;
  assign rx_hdr_ok = s.rx_hdr_ok;
  assign rx_hdr_err = s.rx_hdr_err;
  assign rx_downlink = s.rx_downlink;
  assign rx_level = s.rx_level;

endmodule

// ### verilog/mpf_phy_end.sv
// PHY-side end: APB register access to the framed byte stream
module mpf_phy_end (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpf_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Link to the framer
  mpf_link_if.phy lnk
);
  import mpf_pkg::*;

  typedef struct packed {
    logic [7:0] pd_data;
    logic pd_valid;
    logic pd_last;
    logic dp_ready;
    logic [7:0] rx_byte;
    logic rx_last;
    logic rx_full;
    logic [3:0] fidx;
    logic [7:0] fb0;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } mpf_phy_state_t;

  mpf_phy_state_t s;
  mpf_phy_state_t next_s;

  function automatic mpf_sel_t reg_sel(input logic [APB_AW-1:0] a);
    if (a == REG_TXD) begin
      return SEL_TXD;
    end else if (a == REG_RXD) begin
      return SEL_RXD;
    end else if (a == REG_STAT) begin
      return SEL_STAT;
    end else if (a == REG_MASK) begin
      return SEL_MASK;
    end else begin
      return SEL_NONE;
    end
  endfunction

  always_comb begin
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;
    mpf_sel_t sel;
    ev = '0;
    clr = '0;
    sel = reg_sel(paddr);
    next_s = s;

    if (s.pd_valid && lnk.pd_ready) begin
      next_s.pd_valid = 1'h0;
      ev[ST_TX_TAKEN] = 1'h1;
    end

    if (lnk.dp_valid && s.dp_ready) begin
      next_s.rx_byte = lnk.dp_data;
      next_s.rx_last = lnk.dp_last;
      next_s.rx_full = 1'h1;
      ev[ST_RX_AVAIL] = 1'h1;
      if (s.fidx == 4'h0) begin
        next_s.fb0 = lnk.dp_data;
      end
      if (s.fidx == 4'h1 && !mpf_hdr_clean(s.fb0, lnk.dp_data)) begin
        ev[ST_HDR_BAD] = 1'h1;
      end
      if (lnk.dp_last) begin
        ev[ST_FRAME_END] = 1'h1;
        if (s.fidx < FRAME_MIN_M1) begin
          ev[ST_SHORT] = 1'h1;
        end
        next_s.fidx = 4'h0;
      end else if (s.fidx != FIDX_MAX) begin
        next_s.fidx = s.fidx + 4'h1;
      end
    end

    // One wait state: the answer is registered before pready rises
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'h1;
      next_s.pslverr = sel == SEL_NONE;
      next_s.prdata = '0;
      if (sel == SEL_RXD) begin
        next_s.prdata[7:0] = s.rx_byte;
        next_s.prdata[RXD_LAST_BIT] = s.rx_last;
        next_s.prdata[RXD_FULL_BIT] = s.rx_full;
      end else if (sel == SEL_STAT) begin
        next_s.prdata[ST_W-1:0] = s.stat;
      end else if (sel == SEL_MASK) begin
        next_s.prdata[ST_W-1:0] = s.mask;
      end
    end else if (psel && penable && s.pready) begin
      next_s.pready = 1'h0;
      next_s.pslverr = 1'h0;
      if (pwrite && sel == SEL_TXD) begin
        // A write while the previous byte still waits is lost and flagged
        if (s.pd_valid) begin
          ev[ST_TX_OVR] = 1'h1;
        end else begin
          next_s.pd_data = pwdata[7:0];
          next_s.pd_last = pwdata[TXD_LAST_BIT];
          next_s.pd_valid = 1'h1;
        end
      end else if (pwrite && sel == SEL_STAT) begin
        clr = pwdata[ST_W-1:0];
      end else if (pwrite && sel == SEL_MASK) begin
        next_s.mask = pwdata[ST_W-1:0];
      end else if (!pwrite && sel == SEL_RXD && s.prdata[RXD_FULL_BIT]) begin
        // Only a read that showed a byte frees the slot, so a byte that
        // lands after the snapshot is not lost
        next_s.rx_full = 1'h0;
      end
    end else begin
      next_s.pready = 1'h0;
      next_s.pslverr = 1'h0;
    end

    // Set wins over a clear in the same cycle
    next_s.stat = (s.stat & ~clr) | ev;
    next_s.dp_ready = !next_s.rx_full;
    next_s.irq = |(next_s.stat & next_s.mask);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.pd_data = s.pd_data;
  assign lnk.pd_valid = s.pd_valid;
  assign lnk.pd_last = s.pd_last;
  assign lnk.dp_ready = s.dp_ready;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;

endmodule

// ### verilog/mpf_unused_placeholder.sv
// Intentionally empty: no further design logic

// ### testbench/mpf_link_assertions.sv
// Link checks between the framer and the PHY-side end
module mpf_link_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Framer to PHY side
  input wire logic [7:0] dp_data,
  input wire logic dp_valid,
  input wire logic dp_last,
  input wire logic dp_ready,
  // PHY side to framer
  input wire logic pd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idx;
  logic [3:0] next_idx;

  // Byte index within the frame, saturating so long frames stay legal
  always_comb begin
    next_idx = idx;
    if (dp_valid && dp_ready) begin
      next_idx = dp_last ? 4'h0 : (idx == 4'hF ? idx : idx + 4'h1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idx <= 4'h0;
    end else begin
      idx <= next_idx;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_hold;
    dp_valid && !dp_ready |=>
      dp_valid && $stable(dp_data) && $stable(dp_last);
  endproperty
  a_hold: assert property (p_hold) else $error("link byte dropped");

  property p_align;
    dp_valid && idx == 4'h0 |-> dp_data[7:6] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("align bits set");

  property p_type;
    dp_valid && idx == 4'h0 |-> dp_data[5:4] == 2'h0;
  endproperty
  a_type: assert property (p_type) else $error("header type bad");

  property p_rsv0;
    dp_valid && idx == 4'h0 |-> dp_data[3:0] == 4'h0;
  endproperty
  a_rsv0: assert property (p_rsv0) else $error("reserved set");

  property p_rsv1;
    dp_valid && idx == 4'h1 |-> !dp_data[7];
  endproperty
  a_rsv1: assert property (p_rsv1) else $error("reserved set");

  property p_crc_room;
    dp_valid && dp_last |-> idx >= 4'h7;
  endproperty
  a_crc_room: assert property (p_crc_room) else $error("frame short");

  property p_hdr_burst;
    dp_valid && dp_ready && idx < 4'h2 |=> dp_valid;
  endproperty
  a_hdr_burst: assert property (p_hdr_burst) else $error("header gap");

  property p_rx_ready;
    $past(rstn) |-> pd_ready;
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("rx stall");

  cover property (dp_valid && dp_last && dp_ready);
  cover property (dp_valid && !dp_ready);
  cover property (dp_valid && dp_ready && idx == 4'h2);
endmodule

// ### testbench/mac_pdu_header_framer_bench.sv
// Self-checking bench for the framer and PHY-side end joined by the link
module mac_pdu_header_framer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mpf_pkg::*;
  localparam logic [SNA_W-1:0] OWN_SNA = 48'hA5C3_0F1E_7B29;
  localparam logic [31:0] TX_CRC = 32'h5AC3_91E7;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic tx_start = 1'b0, tx_downlink = 1'b0, tx_valid = 1'b0;
  logic tx_last = 1'b0, tx_idle, tx_done, tx_ready;
  logic [5:0] tx_level = 6'h00;
  logic [31:0] tx_crc32 = 32'h0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data;
  logic rx_valid, rx_last, rx_hdr_ok, rx_hdr_err, rx_downlink;
  logic [5:0] rx_level;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic pready, pslverr, irq, re;
  logic [8:0] rx_q[$];
  int fails = 0, total_checks = 0, ok_cnt = 0, err_cnt = 0, done_cnt = 0;

  mpf_link_if link ();
  mpf_framer mpf_framer_inst (.clock(clock), .rstn(rstn), .subnetwork_address(OWN_SNA),
    .tx_start(tx_start), .tx_downlink(tx_downlink), .tx_level(tx_level),
    .tx_crc32(tx_crc32), .tx_idle(tx_idle), .tx_done(tx_done),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_hdr_ok(rx_hdr_ok), .rx_hdr_err(rx_hdr_err),
    .rx_downlink(rx_downlink), .rx_level(rx_level), .lnk(link));
  mpf_phy_end mpf_phy_end_inst (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .lnk(link));
  mpf_link_assertions mpf_link_assertions_inst (.clock(clock), .rstn(rstn),
    .dp_data(link.dp_data), .dp_valid(link.dp_valid),
    .dp_last(link.dp_last), .dp_ready(link.dp_ready),
    .pd_ready(link.pd_ready));

  initial begin
    forever #50 clock = ~clock;
  end

  // Pulses last a whole cycle, so the falling edge sees them settled
  always @(negedge clock) begin
    if (rx_valid === 1'b1) rx_q.push_back({rx_last, rx_data});
    if (rx_hdr_ok === 1'b1) ok_cnt++;
    if (rx_hdr_err === 1'b1) err_cnt++;
    if (tx_done === 1'b1) done_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Header check, bit serial: address then two header bytes, MSB first
  function automatic logic [7:0] hcs(input logic [63:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 63; i >= 0; i--)
      c = (c[7] ^ m[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tx_frame(input logic dl, input logic [5:0] lvl,
                          input int np);
    logic [7:0] e[$];
    logic [7:0] b1;
    b1 = {1'b0, dl, lvl};
    e = {8'h00, b1, hcs({OWN_SNA, 8'h00, b1})};
    for (int i = 0; i < np; i++) e.push_back(8'(8'h30 + i));
    for (int i = 3; i >= 0; i--) e.push_back(TX_CRC[i*8 +: 8]);
    check(tx_idle, 1'b1);
    @(posedge clock);
    tx_start <= 1'b1;
    tx_downlink <= dl;
    tx_level <= lvl;
    tx_crc32 <= TX_CRC;
    @(posedge clock);
    tx_start <= 1'b0;
    fork
      begin
        int n;
        for (int i = 0; i < np; i++) begin
          tx_data <= e[3+i];
          tx_valid <= 1'b1;
          tx_last <= (i == np - 1);
          n = 0;
          do begin
            @(negedge clock);
            n++;
          end while (tx_ready !== 1'b1 && n < 300);
          @(posedge clock);
        end
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
      begin
        int n;
        for (int i = 0; i < e.size(); i++) begin
          n = 0;
          do begin
            apb(1'b0, REG_RXD, 32'h0);
            n++;
          end while (rq[RXD_FULL_BIT] !== 1'b1 && n < 100);
          check(rq[8:0], {i == e.size() - 1, e[i]});
        end
      end
    join
    apb(1'b0, REG_STAT, 32'h0);
    check(rq[3:1], {np < 7, 2'b01});
  endtask

  task automatic rx_frame(input logic [7:0] b0, input logic [7:0] b1,
                          input logic [7:0] flip, input logic ok);
    logic [7:0] f[$];
    int base, ok0, err0;
    f = {b0, b1, hcs({OWN_SNA, b0, b1}) ^ flip};
    for (int i = 0; i < 11; i++) f.push_back(8'(8'hC0 + i));
    base = rx_q.size();
    ok0 = ok_cnt;
    err0 = err_cnt;
    for (int i = 0; i < f.size(); i++)
      apb(1'b1, REG_TXD, {23'h0, i == f.size() - 1, f[i]});
    // Receive latency is one cycle per byte; allow the last byte to land
    repeat (3) @(posedge clock);
    check(ok_cnt - ok0, ok);
    check(err_cnt - err0, !ok);
    check(rx_q.size() - base, ok ? 11 : 0);
    if (ok) begin
      check({rx_downlink, rx_level}, b1[6:0]);
      for (int i = 0; i < 11; i++)
        check(rx_q[base+i], {i == 10, f[3+i]});
    end
  endtask

  // Receive cases: good downlink, good uplink, bad check, bad fields
  logic [7:0] cb0[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h10, 8'h80, 8'h00};
  logic [7:0] cb1[7] = '{8'h49, 8'h3F, 8'h05, 8'h05, 8'h05, 8'h05, 8'h85};
  logic [7:0] cfl[7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [6:0] cok = 7'b0000011;

  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, REG_MASK, 32'h0);
    check(rq, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(re, 1'b1);
    check(rq, 32'h0);
    tx_frame(1'b1, 6'h05, 7);
    apb(1'b1, REG_STAT, 32'h3F);
    tx_frame(1'b0, 6'h3F, 1);
    check(done_cnt, 2);
    apb(1'b1, 12'h010, 32'h3F);
    apb(1'b0, REG_MASK, 32'h0);
    check(rq, 32'h0);
    apb(1'b1, REG_MASK, 32'h1 << ST_FRAME_END);
    @(posedge clock);
    @(negedge clock);
    check(irq, 1'b1);
    apb(1'b1, REG_STAT, 32'h1 << ST_FRAME_END);
    @(posedge clock);
    @(negedge clock);
    check(irq, 1'b0);
    for (int k = 0; k < 7; k++)
      rx_frame(cb0[k], cb1[k], cfl[k], cok[k]);
    // At least one byte written toward the framer was taken
    apb(1'b0, REG_STAT, 32'h0);
    check(rq[ST_TX_TAKEN], 1'b1);
    tally_and_finish();
  end

  initial begin
    #(100 * 20000);
    fails++;
    tally_and_finish();
  end
endmodule
